/* File: caf_pkg.sv */
// Purpose: shared constants and types of the addressing and program-flow core
// Assumes: 8-bit data, 15-bit program addresses, synchronous memories with one cycle of read latency
// Notes: the opcode map is local to this core
//
// Overview of operation
// RULE1: indirect operand address comes from B or X
// RULE2: post increment or decrement after the access
// RULE3: immediate byte follows the opcode in program memory
// RULE4: short load of B clears upper nibble
// RULE5: table load reads {upper pc, A}, pc restored
// RULE6: program counter is fifteen bits wide
// RULE7: relative jump spans minus 31 to plus 32
// RULE8: code never holds a relative jump of one
// RULE9: absolute jump keeps upper three pc bits
// RULE10: long jump loads all fifteen pc bits
// RULE11: indexed jump loads table byte into low pc
// RULE12: vector dispatch loads two vector bytes into pc
// RULE13: without jumps execution runs in sequence
// RULE14: false condition skips the next instruction
// RULE15: skipped instruction changes nothing at all
// RULE16: call pushes pc, return pops it back
// RULE17: load and exchange move bytes per mode
// RULE18: add, subtract, inc, dec, decimal correct, carry ops
// RULE19: and, or, xor with accumulator
// RULE20: rotate through carry and nibble swap
// RULE21: set or clear memory bit, clear pending
// RULE22: decrement register byte, skip on zero
// RULE23: relative offset is added to jump's address
`default_nettype none

package caf_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // reset values and fixed addresses
  localparam logic [14:0] RESET_PC = 15'h0000;
  localparam logic [7:0]  RESET_SP = 8'h006F;
  localparam logic [14:0] VEC_BASE = 15'h00E0;
  localparam logic [14:0] PC_LAST  = 15'h7FFF;
  localparam logic [14:0] JP_BIAS  = 15'h001F;
  localparam logic [7:0]  REG_BASE = 8'h00F0;

  ////////////////////////////////////////////////////////////////////////////
  // opcodes and opcode groups
  localparam logic [7:0] OP_SC    = 8'h0001;
  localparam logic [7:0] OP_RC    = 8'h0002;
  localparam logic [7:0] OP_IFC   = 8'h0003;
  localparam logic [7:0] OP_IFNC  = 8'h0004;
  localparam logic [7:0] OP_IFEQ  = 8'h0005;
  localparam logic [7:0] OP_IFNE  = 8'h0006;
  localparam logic [7:0] OP_IFGT  = 8'h0007;
  localparam logic [7:0] OP_LONG_ABSOLUTE_JUMP  = 8'h0090;
  localparam logic [7:0] OP_CALL  = 8'h0091;
  localparam logic [7:0] OP_RET   = 8'h0092;
  localparam logic [7:0] OP_RETSK = 8'h0093;
  localparam logic [7:0] OP_JID   = 8'h0094;
  localparam logic [7:0] OP_VIS   = 8'h0095;
  localparam logic [7:0] OP_TABLE_LOAD_TO_ACC  = 8'h0096;
  localparam logic [7:0] OP_RPND  = 8'h0097;
  localparam logic [3:0] GRP_ACC   = 4'h0;
  localparam logic [3:0] GRP_BIT   = 4'h1;
  localparam logic [3:0] GRP_DECREMENT_SKIP_ON_ZERO  = 4'h2;
  localparam logic [3:0] GRP_IFBNE = 4'h3;
  localparam logic [3:0] GRP_JMP   = 4'h8;
  localparam logic [3:0] GRP_LDBS  = 4'hA;
  localparam logic [1:0] GRP_JP    = 2'h1;
  localparam logic [1:0] GRP_ALU   = 2'h3;

  typedef enum logic [2:0] {
    M_B = 3'h0, M_X = 3'h1, M_BINC = 3'h2, M_BDEC = 3'h3,
    M_XINC = 3'h4, M_XDEC = 3'h5, M_IMM = 3'h6, M_DIR = 3'h7
  } caf_mode_e;

  typedef enum logic [3:0] {
    ALU_ADD = 4'h0, ALU_ADC = 4'h1, ALU_SUBC = 4'h2, ALU_AND = 4'h3,
    ALU_OR = 4'h4, ALU_XOR = 4'h5, ALU_LD = 4'h6, ALU_XCH = 4'h7,
    ALU_INC = 4'h8, ALU_DEC = 4'h9, ALU_DCOR = 4'hA, ALU_CLR = 4'hB,
    ALU_RRC = 4'hC, ALU_RLC = 4'hD, ALU_SWAP = 4'hE, ALU_NOP = 4'hF
  } caf_aluop_e;

  typedef enum logic [3:0] {
    ST_FETCH = 4'h0, ST_FWAIT = 4'h1, ST_DEC = 4'h2, ST_OWAIT = 4'h3,
    ST_OCAP = 4'h4, ST_EXEC = 4'h5, ST_DWAIT = 4'h6, ST_DCAP = 4'h7,
    ST_PUSHHI = 4'h8, ST_POPWAIT = 4'h9, ST_POPCAP = 4'hA, ST_TWAIT = 4'hB,
    ST_TCAP = 4'hC
  } caf_state_e;

  ////////////////////////////////////////////////////////////////////////////
  // carriers
  typedef struct packed {
    logic [14:0] addr;
    logic        re;
  } caf_pmreq_s;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       we;
    logic       re;
  } caf_dmreq_s;

  typedef struct packed {
    logic [14:0] pc;
    logic [7:0]  acc;
    logic [7:0]  bReg;
    logic [7:0]  xReg;
    logic [7:0]  sp;
    logic        carry;
    logic        halfCarry;
  } caf_stat_s;

  typedef struct packed {
    logic [7:0] res;
    logic       c;
    logic       hc;
    logic       updC;
    logic       updHc;
  } caf_alures_s;

endpackage

`default_nettype wire

/* File: caf_alu.sv */
// Purpose: byte arithmetic and logic for the accumulator
// Assumes: carry means no borrow on subtraction
// Notes: purely combinational
`default_nettype none

module caf_alu
  import caf_pkg::*;
(
  input  wire caf_pkg::caf_aluop_e  aluOp,
  input  wire logic [7:0]           a,
  input  wire logic [7:0]           b,
  input  wire logic                 cin,
  input  wire logic                 hcin,
  output var  caf_pkg::caf_alures_s res
);
  logic [8:0] sum9;
  logic [4:0] half5;
  logic [7:0] bx;
  logic [7:0] adj;

  always_comb
  begin
    res = '0;
    res.res = a;
    bx = (aluOp == ALU_SUBC) ? ~b : b;
    sum9 = {1'b0, a} + {1'b0, bx} + {8'h00, cin};
    half5 = {1'b0, a[3:0]} + {1'b0, bx[3:0]} + {4'h0, cin};
    adj = {(cin || a[7:4] > 4'h9) ? 4'h6 : 4'h0, (hcin || a[3:0] > 4'h9) ? 4'h6 : 4'h0};
    case (aluOp)
      ALU_ADD:  res.res = a + b; // RULE18
      ALU_ADC, ALU_SUBC:
      begin
        res.res = sum9[7:0]; // RULE18
        res.c = sum9[8];
        res.hc = half5[4];
        res.updC = 1'b1;
        res.updHc = 1'b1;
      end
      ALU_AND:  res.res = a & b; // RULE19
      ALU_OR:   res.res = a | b; // RULE19
      ALU_XOR:  res.res = a ^ b; // RULE19
      ALU_LD, ALU_XCH: res.res = b; // RULE17
      ALU_INC:  res.res = a + 8'h01; // RULE18
      ALU_DEC:  res.res = a - 8'h01; // RULE18
      ALU_DCOR: res.res = a + adj; // RULE18
      ALU_CLR:  res.res = 8'h00; // RULE18
      ALU_RRC:
      begin
        res.res = {cin, a[7:1]}; // RULE20
        res.c = a[0];
        res.updC = 1'b1;
      end
      ALU_RLC:
      begin
        res.res = {a[6:0], cin}; // RULE20
        res.c = a[7];
        res.updC = 1'b1;
      end
      ALU_SWAP: res.res = {a[3:0], a[7:4]}; // RULE20
      default:  res.res = a;
    endcase
  end

endmodule // caf_alu

`default_nettype wire

/* File: caf_core.sv */
// Purpose: fetch, operand addressing and program-flow sequencer of the 8-bit core
// Assumes: program and data memories answer one cycle after a read request
// Notes: B, X and SP are held inside the core, not aliased into data memory
`default_nettype none

module caf_core
  import caf_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                reset_n,
  input  wire logic [7:0]          pmRdData,
  input  wire logic [7:0]          dmRdData,
  input  wire logic [3:0]          intVecIdx,
  output var  caf_pkg::caf_pmreq_s pmReq,
  output var  caf_pkg::caf_dmreq_s dmReq,
  output var  logic                swPendClr,
  output var  caf_pkg::caf_stat_s  coreStat
);
  import caf_pkg::*;

  typedef struct packed {
    caf_state_e  st;
    logic [14:0] pc;
    logic [14:0] instrAddr;
    logic [7:0]  op;
    logic [7:0]  b2;
    logic [7:0]  b3;
    logic [1:0]  rem;
    logic [7:0]  hold;
    logic [7:0]  acc;
    logic [7:0]  bReg;
    logic [7:0]  xReg;
    logic [7:0]  sp;
    logic        carry;
    logic        hc;
    logic        skip;
    logic        swPendClr;
    caf_pmreq_s  pm;
    caf_dmreq_s  dm;
  } caf_core_s;

  localparam caf_core_s CORE_RST = '{st: ST_FETCH, pc: RESET_PC, sp: RESET_SP, default: '0};

  caf_core_s   r_r;
  caf_core_s   r_nxt;
  caf_aluop_e  aluSel;
  caf_mode_e   opMode;
  caf_alures_s aluRes;
  logic [7:0]  aluB;
  logic [7:0]  ptrVal;
  logic [14:0] jpTarget;
  logic        doApply;

  ////////////////////////////////////////////////////////////////////////////
  // decode helpers
  function automatic logic isAlu(input logic [7:0] op);
    return op[7:6] == GRP_ALU;
  endfunction

  function automatic logic [1:0] instrLen(input logic [7:0] op);
    if (op == OP_LONG_ABSOLUTE_JUMP || op == OP_CALL)
      return 2'd3;
    if (op[7:4] == GRP_JMP || op == OP_IFEQ || op == OP_IFNE || op == OP_IFGT)
      return 2'd2;
    if (isAlu(op) && (op[2:0] == M_IMM || op[2:0] == M_DIR))
      return 2'd2;
    return 2'd1;
  endfunction

  function automatic logic ptrIsB(input caf_mode_e m);
    return m == M_B || m == M_BINC || m == M_BDEC;
  endfunction

  assign opMode   = caf_mode_e'(r_r.op[2:0]);
  assign ptrVal   = ptrIsB(opMode) ? r_r.bReg : r_r.xReg;
  assign jpTarget = r_r.instrAddr + {9'h000, r_r.op[5:0]} - JP_BIAS; // RULE7 RULE23
  assign aluB     = (r_r.st == ST_DCAP) ? dmRdData : r_r.b2;

  always_comb
  begin
    if (isAlu(r_r.op))
      aluSel = caf_aluop_e'({1'b0, r_r.op[5:3]});
    else if (r_r.op[7:4] == GRP_ACC && r_r.op[3])
      aluSel = caf_aluop_e'({1'b1, r_r.op[2:0]});
    else
      aluSel = ALU_NOP;
  end

  caf_alu u_alu (
    .aluOp (aluSel),
    .a     (r_r.acc),
    .b     (aluB),
    .cin   (r_r.carry),
    .hcin  (r_r.hc),
    .res   (aluRes)
  );

  ////////////////////////////////////////////////////////////////////////////
  // sequencer
  always_comb
  begin
    r_nxt = r_r;
    r_nxt.pm.re = 1'b0;
    r_nxt.dm.re = 1'b0;
    r_nxt.dm.we = 1'b0;
    r_nxt.swPendClr = 1'b0;
    doApply = 1'b0;
    case (r_r.st)
      ST_FETCH:
      begin
        r_nxt.pm.addr = r_r.pc;
        r_nxt.pm.re = 1'b1;
        r_nxt.instrAddr = r_r.pc;
        r_nxt.pc = r_r.pc + 15'h0001; // RULE6 RULE13
        r_nxt.st = ST_FWAIT;
      end
      ST_FWAIT: r_nxt.st = ST_DEC;
      ST_DEC:
      begin
        r_nxt.op = pmRdData;
        r_nxt.rem = instrLen(pmRdData) - 2'd1;
        r_nxt.st = ST_EXEC;
        if (instrLen(pmRdData) != 2'd1)
        begin
          r_nxt.pm.addr = r_r.pc; // RULE3
          r_nxt.pm.re = 1'b1;
          r_nxt.pc = r_r.pc + 15'h0001;
          r_nxt.st = ST_OWAIT;
        end
        else if (r_r.skip)
        begin
          r_nxt.skip = 1'b0; // RULE15
          r_nxt.st = ST_FETCH;
        end
      end
      ST_OWAIT: r_nxt.st = ST_OCAP;
      ST_OCAP:
      begin
        if (r_r.rem == instrLen(r_r.op) - 2'd1)
          r_nxt.b2 = pmRdData; // RULE3
        else
          r_nxt.b3 = pmRdData;
        r_nxt.rem = r_r.rem - 2'd1;
        r_nxt.st = ST_EXEC;
        if (r_r.rem != 2'd1)
        begin
          r_nxt.pm.addr = r_r.pc;
          r_nxt.pm.re = 1'b1;
          r_nxt.pc = r_r.pc + 15'h0001;
          r_nxt.st = ST_OWAIT;
        end
        else if (r_r.skip)
        begin
          r_nxt.skip = 1'b0; // RULE15
          r_nxt.st = ST_FETCH;
        end
      end
      ST_EXEC:
      begin
        r_nxt.st = ST_FETCH;
        if (isAlu(r_r.op))
        begin
          // exchange with an immediate has nothing to write back, so it acts as a load
          if (opMode == M_IMM)
            doApply = 1'b1;
          else
          begin
            r_nxt.dm.addr = (opMode == M_DIR) ? r_r.b2 : ptrVal; // RULE1
            r_nxt.dm.re = 1'b1;
            r_nxt.st = ST_DWAIT;
          end
        end
        else if (r_r.op[7:6] == GRP_JP)
          r_nxt.pc = jpTarget; // RULE7 RULE23
        else if (r_r.op[7:4] == GRP_JMP)
          r_nxt.pc = {r_r.pc[14:12], r_r.op[3:0], r_r.b2}; // RULE9
        else if (r_r.op[7:4] == GRP_LDBS)
          r_nxt.bReg = {4'h0, r_r.op[3:0]}; // RULE4
        else if (r_r.op[7:4] == GRP_IFBNE)
          r_nxt.skip = (r_r.bReg[3:0] == r_r.op[3:0]); // RULE14
        else if (r_r.op[7:4] == GRP_DECREMENT_SKIP_ON_ZERO || r_r.op[7:4] == GRP_BIT)
        begin
          r_nxt.dm.addr = (r_r.op[7:4] == GRP_DECREMENT_SKIP_ON_ZERO) ? {REG_BASE[7:4], r_r.op[3:0]} : r_r.bReg;
          r_nxt.dm.re = 1'b1;
          r_nxt.st = ST_DWAIT;
        end
        else if (r_r.op[7:4] == GRP_ACC && r_r.op[3])
          doApply = 1'b1; // RULE18 RULE20
        else
          case (r_r.op)
            OP_SC:   r_nxt.carry = 1'b1; // RULE18
            OP_RC:   r_nxt.carry = 1'b0; // RULE18
            OP_IFC:  r_nxt.skip = !r_r.carry; // RULE14
            OP_IFNC: r_nxt.skip = r_r.carry; // RULE14
            OP_IFEQ: r_nxt.skip = (r_r.acc != r_r.b2); // RULE14
            OP_IFNE: r_nxt.skip = (r_r.acc == r_r.b2); // RULE14
            OP_IFGT: r_nxt.skip = (r_r.acc <= r_r.b2); // RULE14
            OP_LONG_ABSOLUTE_JUMP: r_nxt.pc = {r_r.b2[6:0], r_r.b3}; // RULE10
            OP_CALL:
            begin
              r_nxt.dm.addr = r_r.sp; // RULE16
              r_nxt.dm.wdata = r_r.pc[7:0];
              r_nxt.dm.we = 1'b1;
              r_nxt.sp = r_r.sp - 8'h01;
              r_nxt.st = ST_PUSHHI;
            end
            OP_RET, OP_RETSK:
            begin
              r_nxt.sp = r_r.sp + 8'h01; // RULE16
              r_nxt.dm.addr = r_r.sp + 8'h01;
              r_nxt.dm.re = 1'b1;
              r_nxt.rem = 2'd0;
              r_nxt.st = ST_POPWAIT;
            end
            OP_JID, OP_TABLE_LOAD_TO_ACC:
            begin
              // the table pointer borrows the upper pc bits; the table read leaves pc alone, though JID then loads the fetched byte into low pc
              r_nxt.pm.addr = {r_r.pc[14:8], r_r.acc}; // RULE5 RULE11
              r_nxt.pm.re = 1'b1;
              r_nxt.st = ST_TWAIT;
            end
            OP_VIS:
            begin
              r_nxt.pm.addr = VEC_BASE + {10'h000, intVecIdx, 1'b0}; // RULE12
              r_nxt.pm.re = 1'b1;
              r_nxt.rem = 2'd0;
              r_nxt.st = ST_TWAIT;
            end
            OP_RPND: r_nxt.swPendClr = 1'b1; // RULE21
            default: r_nxt.st = ST_FETCH;
          endcase
      end
      ST_DWAIT: r_nxt.st = ST_DCAP;
      ST_DCAP:
      begin
        r_nxt.st = ST_FETCH;
        if (isAlu(r_r.op))
        begin
          doApply = 1'b1; // RULE17
          if (aluSel == ALU_XCH)
          begin
            r_nxt.dm.wdata = r_r.acc; // RULE17
            r_nxt.dm.we = 1'b1;
          end
          case (opMode)
            M_BINC:  r_nxt.bReg = r_r.bReg + 8'h01; // RULE2
            M_BDEC:  r_nxt.bReg = r_r.bReg - 8'h01; // RULE2
            M_XINC:  r_nxt.xReg = r_r.xReg + 8'h01; // RULE2
            M_XDEC:  r_nxt.xReg = r_r.xReg - 8'h01; // RULE2
            default: r_nxt.bReg = r_r.bReg;
          endcase
        end
        else if (r_r.op[7:4] == GRP_DECREMENT_SKIP_ON_ZERO)
        begin
          r_nxt.dm.wdata = dmRdData - 8'h01; // RULE22
          r_nxt.dm.we = 1'b1;
          r_nxt.skip = (dmRdData == 8'h01); // RULE22
        end
        else
        begin
          r_nxt.dm.wdata = r_r.op[3] ? dmRdData & ~(8'h01 << r_r.op[2:0])
                                     : dmRdData | (8'h01 << r_r.op[2:0]); // RULE21
          r_nxt.dm.we = 1'b1;
        end
      end
      ST_PUSHHI:
      begin
        r_nxt.dm.addr = r_r.sp; // RULE16
        r_nxt.dm.wdata = {1'b0, r_r.pc[14:8]};
        r_nxt.dm.we = 1'b1;
        r_nxt.sp = r_r.sp - 8'h01;
        r_nxt.pc = {r_r.b2[6:0], r_r.b3};
        r_nxt.st = ST_FETCH;
      end
      ST_POPWAIT: r_nxt.st = ST_POPCAP;
      ST_POPCAP:
      begin
        r_nxt.st = ST_FETCH;
        if (r_r.rem == 2'd0)
        begin
          r_nxt.hold = dmRdData;
          r_nxt.sp = r_r.sp + 8'h01;
          r_nxt.dm.addr = r_r.sp + 8'h01;
          r_nxt.dm.re = 1'b1;
          r_nxt.rem = 2'd1;
          r_nxt.st = ST_POPWAIT;
        end
        else
        begin
          r_nxt.pc = {r_r.hold[6:0], dmRdData}; // RULE16
          r_nxt.skip = (r_r.op == OP_RETSK);
        end
      end
      ST_TWAIT: r_nxt.st = ST_TCAP;
      ST_TCAP:
      begin
        r_nxt.st = ST_FETCH;
        if (r_r.op == OP_TABLE_LOAD_TO_ACC)
          r_nxt.acc = pmRdData; // RULE5
        else if (r_r.op == OP_JID)
          r_nxt.pc = {r_r.pc[14:8], pmRdData}; // RULE11
        else if (r_r.rem == 2'd0)
        begin
          r_nxt.hold = pmRdData;
          r_nxt.pm.addr = r_r.pm.addr + 15'h0001; // RULE12
          r_nxt.pm.re = 1'b1;
          r_nxt.rem = 2'd1;
          r_nxt.st = ST_TWAIT;
        end
        else
          r_nxt.pc = {r_r.hold[6:0], pmRdData}; // RULE12
      end
      default: r_nxt.st = ST_FETCH;
    endcase
    if (doApply)
    begin
      r_nxt.acc = aluRes.res;
      if (aluRes.updC)
        r_nxt.carry = aluRes.c;
      if (aluRes.updHc)
        r_nxt.hc = aluRes.hc;
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      r_r <= CORE_RST;
    else
      r_r <= r_nxt;
  end

  assign pmReq     = r_r.pm;
  assign dmReq     = r_r.dm;
  assign swPendClr = r_r.swPendClr;
  assign coreStat  = '{pc: r_r.pc, acc: r_r.acc, bReg: r_r.bReg, xReg: r_r.xReg,
                       sp: r_r.sp, carry: r_r.carry, halfCarry: r_r.hc};

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  property p_ind_addr;
    (r_r.st == ST_EXEC && isAlu(r_r.op) && opMode == M_X) |=> dmReq.re && dmReq.addr == $past(r_r.xReg);
  endproperty
  a_ind_addr: assert property (p_ind_addr) else $error("indirect address not X"); // RULE1

  property p_post_inc;
    (r_r.st == ST_DCAP && isAlu(r_r.op) && opMode == M_BINC) |=> r_r.bReg == 8'($past(r_r.bReg) + 8'h01);
  endproperty
  a_post_inc: assert property (p_post_inc) else $error("B not incremented"); // RULE2

  property p_imm_fetch;
    (r_r.st == ST_DEC && instrLen(pmRdData) != 2'd1) |=> pmReq.re && pmReq.addr == $past(r_r.pc) ##1 r_r.st == ST_OCAP;
  endproperty
  a_imm_fetch: assert property (p_imm_fetch) else $error("operand fetch address wrong"); // RULE3

  property p_ldb_short;
    (r_r.st == ST_EXEC && r_r.op[7:4] == GRP_LDBS) |=> r_r.bReg == {4'h0, $past(r_r.op[3:0])};
  endproperty
  a_ldb_short: assert property (p_ldb_short) else $error("short load of B wrong"); // RULE4

  property p_table_load_to_acc;
    (r_r.st == ST_TCAP && r_r.op == OP_TABLE_LOAD_TO_ACC) |=> r_r.acc == $past(pmRdData) && r_r.pc == $past(r_r.pc);
  endproperty
  a_table_load_to_acc: assert property (p_table_load_to_acc) else $error("table load wrong"); // RULE5

  property p_pc_wrap;
    (r_r.st == ST_FETCH && r_r.pc == PC_LAST) |=> r_r.pc == RESET_PC;
  endproperty
  a_pc_wrap: assert property (p_pc_wrap) else $error("pc not 15 bits"); // RULE6

  property p_jp;
    (r_r.st == ST_EXEC && r_r.op[7:6] == GRP_JP) |=> r_r.pc == 15'($past(r_r.instrAddr) + {9'h000, $past(r_r.op[5:0])} - JP_BIAS);
  endproperty
  a_jp: assert property (p_jp) else $error("relative target wrong"); // RULE7

  property p_jmp;
    (r_r.st == ST_EXEC && r_r.op[7:4] == GRP_JMP) |=> r_r.pc == {$past(r_r.pc[14:12]), $past(r_r.op[3:0]), $past(r_r.b2)};
  endproperty
  a_jmp: assert property (p_jmp) else $error("absolute jump wrong"); // RULE9

  property p_jid;
    (r_r.st == ST_TCAP && r_r.op == OP_JID) |=> r_r.pc == {$past(r_r.pc[14:8]), $past(pmRdData)};
  endproperty
  a_jid: assert property (p_jid) else $error("indexed jump wrong"); // RULE11

  property p_seq;
    (r_r.st == ST_FETCH) |-> ##2 r_r.st == ST_DEC;
  endproperty
  a_seq: assert property (p_seq) else $error("fetch sequence broken"); // RULE13

  property p_skip;
    (r_r.st == ST_EXEC && r_r.op == OP_IFC && !r_r.carry) |=> r_r.skip ##3 !r_r.skip;
  endproperty
  a_skip: assert property (p_skip) else $error("skip not taken"); // RULE14

  property p_no_exec;
    (r_r.st == ST_EXEC) |-> !r_r.skip;
  endproperty
  a_no_exec: assert property (p_no_exec) else $error("skipped instruction executed"); // RULE15

  property p_call;
    (r_r.st == ST_EXEC && r_r.op == OP_CALL) |=> dmReq.we && dmReq.wdata == $past(r_r.pc[7:0]) ##1 dmReq.we && r_r.pc == {$past(r_r.b2[6:0], 2), $past(r_r.b3, 2)};
  endproperty
  a_call: assert property (p_call) else $error("call push wrong"); // RULE16

  property p_decrement_skip_on_zero;
    (r_r.st == ST_DCAP && r_r.op[7:4] == GRP_DECREMENT_SKIP_ON_ZERO) |=> dmReq.we && r_r.skip == ($past(dmRdData) == 8'h01);
  endproperty
  a_decrement_skip_on_zero: assert property (p_decrement_skip_on_zero) else $error("decrement skip wrong"); // RULE22

  c_xch_inc: cover property (r_r.st == ST_DCAP && aluSel == ALU_XCH && opMode == M_BINC);
  c_ret: cover property (r_r.st == ST_POPCAP && r_r.rem == 2'd1);
  c_vis: cover property (r_r.st == ST_TCAP && r_r.op == OP_VIS && r_r.rem == 2'd1);
  c_skip: cover property (r_r.st == ST_DEC && r_r.skip);

endmodule // caf_core

`default_nettype wire

/* File: caf_mem_model.sv */
// Purpose: program and data memory arrays that face the core
// Assumes: one read request answered on the edge that sees re, writes land on the edge that sees we
// Notes: read data stands for one cycle only, then flips so a late sample cannot pass
`default_nettype none

module caf_mem_model
  import caf_pkg::*;
(
  input  wire logic                clk,
  input  wire caf_pkg::caf_pmreq_s pmReq,
  input  wire caf_pkg::caf_dmreq_s dmReq,
  output var  logic [7:0]          pmRdData,
  output var  logic [7:0]          dmRdData
);
  logic [7:0] pm [0:32767];
  logic [7:0] dm [0:255];

  initial
  begin
    pmRdData = 8'h00;
    dmRdData = 8'h00;
    foreach (pm[i]) pm[i] = 8'h00;
    foreach (dm[i]) dm[i] = 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////////
  // stale data is inverted, not held, so the core must sample in time
  always @(posedge clk)
  begin
    pmRdData <= pmReq.re ? pm[pmReq.addr] : ~pmRdData;
    dmRdData <= dmReq.re ? dm[dmReq.addr] : ~dmRdData;
    if (dmReq.we) dm[dmReq.addr] <= dmReq.wdata;
  end
endmodule // caf_mem_model

`default_nettype wire

/* File: test_cpu_addressing_and_flow.sv */
// Purpose: self-checking bench of the addressing and program-flow core
// Assumes: memory answers per the hand-over timing
// Notes: checkpoints are fetch addresses; expected state is worked out here
`default_nettype none

module test_cpu_addressing_and_flow
  import caf_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic       clk       = 1'b0;
  logic       reset_n   = 1'b0;
  logic [3:0] intVecIdx = 4'h3;
  logic [7:0] pmRdData;
  logic [7:0] dmRdData;
  caf_pmreq_s pmReq;
  caf_dmreq_s dmReq;
  caf_stat_s  coreStat;
  logic       swPendClr;
  int         errors    = 0;
  int         cmp_count = 0;
  int         pulses    = 0;
  logic [7:0] imm;
  logic [7:0] dm5;
  logic [7:0] tbl;

  always #5 clk = ~clk;

  caf_core uut (.clk(clk), .reset_n(reset_n), .pmRdData(pmRdData), .dmRdData(dmRdData),
    .intVecIdx(intVecIdx), .pmReq(pmReq), .dmReq(dmReq), .swPendClr(swPendClr), .coreStat(coreStat));
  caf_mem_model mem (.clk(clk), .pmReq(pmReq), .dmReq(dmReq), .pmRdData(pmRdData), .dmRdData(dmRdData));

  always @(posedge clk) if (swPendClr === 1'b1) pulses <= pulses + 1;

  ////////////////////////////////////////////////////////////////////////////
  task automatic close_out;
    $display("errors=%0d compares=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic cmp(input logic [23:0] got, input logic [23:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // bounded wait for a fetch at a given address
  task automatic reach(input logic [14:0] a);
    int n;
    n = 0;
    while (!(pmReq.re === 1'b1 && pmReq.addr === a) && n < 400)
    begin
      @(negedge clk);
      n++;
    end
    cmp(24'(pmReq.addr), 24'(a));
  endtask

  task automatic ld(input int a, input logic [7:0] q[$]);
    foreach (q[i]) mem.pm[a + i] = q[i];
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #50000;
    errors++;
    close_out;
  end

  initial
  begin
    void'($urandom(32'hf5ee));
    imm = 8'($urandom());
    dm5 = 8'h10 + 8'($urandom() % 64);
    tbl = 8'($urandom());
    @(negedge clk);
    intVecIdx = 4'($urandom());
    // no relative jump of one anywhere in this image
    ld(0, {8'hA5, 8'hF6, imm, 8'hFA, 8'h96, 8'h90, 8'h51, 8'h00});
    mem.pm[dm5] = tbl;
    mem.dm[5] = dm5;
    mem.dm[8'hF0] = 8'h02;
    ld(32'h5100, {8'h7F, 8'h83, 8'h45});
    ld(32'h5120, {8'h40});
    ld(32'h5345, {8'h01, 8'h03, 8'h0B, 8'h04, 8'h08, 8'h94});
    mem.pm[15'h5300] = 8'h80;
    ld(32'h5380, {8'h91, 8'h60, 8'h00, 8'h08, 8'h20, 8'h08, 8'h20, 8'h08, 8'h95});
    mem.pm[15'h6000] = 8'h93;
    ld(int'(VEC_BASE) + 2 * int'(intVecIdx), {8'h2A, 8'h10});
    ld(32'h2A10, {8'h97, 8'h00});
    repeat (4) @(negedge clk);
    reset_n = 1'b1;
    reach(15'h0004);
    cmp(24'(coreStat.acc), 24'(dm5));
    cmp(24'(coreStat.bReg), 24'h06);
    reach(15'h0005);
    reach(15'h5100);
    cmp(24'(coreStat.acc), 24'(tbl));
    cmp(24'(mem.dm[5]), 24'(imm));
    reach(15'h5120);
    reach(15'h5101);
    reach(15'h5345);
    reach(15'h5380);
    cmp(24'(coreStat.acc), 24'h00);
    cmp(24'(coreStat.carry), 24'h01);
    reach(15'h6000);
    cmp(24'(coreStat.sp), 24'h6D);
    reach(15'h5384);
    reach(15'h5388);
    reach(15'h2A10);
    cmp(24'(coreStat.acc), 24'h01);
    cmp(24'(coreStat.sp), 24'h6F);
    cmp({mem.dm[8'h6E], mem.dm[8'h6F], mem.dm[8'hF0]}, 24'h538300);
    reach(15'h2A12);
    cmp(24'(pulses), 24'h01);
    close_out;
  end
endmodule // test_cpu_addressing_and_flow

`default_nettype wire
